// File: src/pcif_irq_flags.v
`timescale 1ns/1ps
`include "pcif_regs.vh"

// Contract
// R1: Writing a one to a bit of the flag-set register raises the matching flag.
// R2: Writing a one to a bit of the flag-clear register drops that flag; zeros leave it.
// R3: The enable register holds a read/write enable per source, all zero after reset.
// R4: Set, clear and enable share the layout bit4 trig_cmp down to bit0 wrap_low.
// R5: Software writes zeros to bits 31:5 of set, clear and enable.
// R6: Direction change has its own bit 2 in all three registers and acts like the rest.
// R7: Hardware raises each flag on its counter event, wrap_low on main counter underflow.
// R8: The interrupt line is high while any flag and its enable are both set.
module pcif_irq_flags (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        triggered_compare,
    input  wire        aux_counter_wrap,
    input  wire        direction_change,
    input  wire        counter_wrap_high,
    input  wire        counter_wrap_low,
    output wire        irq
);

    // ------------------------------------------------------------------
    // event capture
    // ------------------------------------------------------------------
    wire [4:0] evt_raw;
    wire [4:0] evt_sync;
    reg  [4:0] evt_prev_reg;
    wire [4:0] evt_pulse;

    assign evt_raw[`PCIF_BIT_TRIG_CMP] = triggered_compare;
    assign evt_raw[`PCIF_BIT_AUX_WRAP] = aux_counter_wrap;
    assign evt_raw[`PCIF_BIT_DIR_CHG]  = direction_change; // R6
    assign evt_raw[`PCIF_BIT_WRAP_HI]  = counter_wrap_high;
    assign evt_raw[`PCIF_BIT_WRAP_LO]  = counter_wrap_low;

    // core events may come from another clock, so resync first
    pcif_sync2 #(
        .W (`PCIF_NSRC)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (evt_raw),
        .q       (evt_sync)
    );

    // rising edge per source: a held level counts once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_prev_reg <= `PCIF_FIELD_RESET;
        end else begin
            evt_prev_reg <= evt_sync;
        end
    end

    assign evt_pulse = evt_sync & ~evt_prev_reg; // R7

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire       wr_en  = psel & penable & pwrite;
    wire       wr_set = wr_en & hit(paddr, `PCIF_OFF_FLAG_SET);
    wire       wr_clr = wr_en & hit(paddr, `PCIF_OFF_FLAG_CLR);
    wire       wr_ien = wr_en & hit(paddr, `PCIF_OFF_ENABLE);
    wire       mapped = hit(paddr, `PCIF_OFF_FLAG) | hit(paddr, `PCIF_OFF_FLAG_SET) |
                        hit(paddr, `PCIF_OFF_FLAG_CLR) | hit(paddr, `PCIF_OFF_ENABLE);
    // bits 31:5 are dropped; software is expected to write zeros there
    wire [4:0] wmask  = pwdata[4:0]; // R5 R4

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------------
    // flags and enables
    // ------------------------------------------------------------------
    reg  [4:0] flag_reg;
    reg  [4:0] flag_next;
    reg  [4:0] ien_reg;

    // hardware events and set writes beat a clear in the same cycle
    always @* begin
        flag_next = flag_reg;
        if (wr_clr) begin
            flag_next = flag_next & ~wmask; // R2
        end
        if (wr_set) begin
            flag_next = flag_next | wmask; // R1
        end
        flag_next = flag_next | evt_pulse; // R7
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= `PCIF_FIELD_RESET;
            ien_reg  <= `PCIF_FIELD_RESET;
        end else begin
            flag_reg <= flag_next;
            if (wr_ien) begin
                ien_reg <= wmask; // R3
            end
        end
    end

    // level output, no edge so software sees a clean clear
    assign irq = |(flag_reg & ien_reg); // R8

    // ------------------------------------------------------------------
    // read data, registered in the setup phase
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `PCIF_DATA_ZERO;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `PCIF_OFF_FLAG:   prdata <= {`PCIF_PAD_ZERO, flag_reg};
                `PCIF_OFF_ENABLE: prdata <= {`PCIF_PAD_ZERO, ien_reg}; // R3
                default:          prdata <= `PCIF_DATA_ZERO;
            endcase
        end
    end

endmodule // pcif_irq_flags

// File: common/pcif_regs.vh
`ifndef PCIF_REGS_VH
`define PCIF_REGS_VH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define PCIF_ADDR_W        12
`define PCIF_OFF_FLAG      12'h018
`define PCIF_OFF_FLAG_SET  12'h01C
`define PCIF_OFF_FLAG_CLR  12'h020
`define PCIF_OFF_ENABLE    12'h024

// ----------------------------------------------------------------------
// field layout shared by flag, set, clear and enable
// ----------------------------------------------------------------------
`define PCIF_NSRC          5
`define PCIF_BIT_TRIG_CMP  4
`define PCIF_BIT_AUX_WRAP  3
`define PCIF_BIT_DIR_CHG   2
`define PCIF_BIT_WRAP_HI   1
`define PCIF_BIT_WRAP_LO   0
`define PCIF_FIELD_RESET   5'h00
`define PCIF_PAD_W         27
`define PCIF_PAD_ZERO      27'h0000000
`define PCIF_DATA_ZERO     32'h00000000

`endif

// File: src/pcif_sync2.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// two-stage synchroniser for event levels from outside the clock domain
// ----------------------------------------------------------------------
module pcif_sync2 #(
    parameter W = 5
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule // pcif_sync2

// File: bench/pcif_irq_flags_checker.sv
`timescale 1ns/1ps
module pcif_irq_flags_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire       w = psel && penable && pwrite;
    wire [4:0] d = pwdata[4:0];
    reg  [4:0] en_reg;
    // shadow enable, so reads and irq can be judged without the bodies
    always @(posedge pclk or negedge presetn)
        if (!presetn) en_reg <= 5'h00;
        else if (w && paddr == 12'h024) en_reg <= d;
    sequence s_rd;
        psel && !penable && !pwrite && paddr == 12'h024 ##1 penable;
    endsequence
    property p_set; w && paddr == 12'h01C && |(d & en_reg) |=> irq; endproperty
    property p_clr; w && paddr == 12'h020 && d == 5'h1F |=> !irq; endproperty
    property p_off; w && paddr == 12'h024 && d == 5'h00 |=> !irq; endproperty
    property p_rd; s_rd |-> prdata == {27'h0, en_reg}; endproperty
    property p_fall; $fell(irq) |-> $past(w) && $past(paddr[5]); endproperty
    property p_err; psel && penable && paddr > 12'h024 |-> pslverr; endproperty
    property p_ok; psel && penable && paddr == 12'h01C |-> pready && !pslverr; endproperty
    property p_rst; $rose(presetn) |-> !irq; endproperty
    a_set: assert property (p_set) else $error("irq missing after set");
    a_clr: assert property (p_clr) else $error("irq after clear");
    a_off: assert property (p_off) else $error("irq while disabled");
    a_rd: assert property (p_rd) else $error("enable readback");
    a_fall: assert property (p_fall) else $error("irq dropped alone");
    a_err: assert property (p_err) else $error("no slave error");
    a_ok: assert property (p_ok) else $error("bad answer");
    a_rst: assert property (p_rst) else $error("irq out of reset");
endmodule // pcif_irq_flags_checker
bind pcif_irq_flags pcif_irq_flags_checker chk_i (.*);

// File: bench/pcif_irq_flags_test.sv
`timescale 1ns/1ps
`define CMP(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module pcif_irq_flags_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, irq, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [4:0]  ev = 0;
    int          fail_count = 0, compares = 0;
    always #2 pclk = ~pclk;
    pcif_irq_flags pcif_irq_flags_i (.*, .triggered_compare(ev[4]), .aux_counter_wrap(ev[3]),
        .direction_change(ev[2]), .counter_wrap_high(ev[1]), .counter_wrap_low(ev[0]));
    // one apb transfer; holds everything until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] x);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= x;
        @(posedge pclk) penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task chk(input logic [4:0] e);
        apb(1'h0, 12'h018, 32'h0);
        `CMP("flags", {27'h0, e}, rd)
    endtask
    task wrap_up;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #40000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 12'h024, 32'h0);
        `CMP("enable", 32'h0, rd)
        chk(5'h0);
        $display("reset test done");
        apb(1'h1, 12'h024, 32'h1F);
        apb(1'h0, 12'h024, 32'h0);
        `CMP("enable", 32'h1F, rd)
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 12'h01C, 32'h1 << i);
            chk(5'h1 << i);
            `CMP("irq", 1'h1, irq)
            apb(1'h1, 12'h020, 32'h1 << i);
            chk(5'h0);
            ev <= 5'h1 << i;
            repeat (3) @(posedge pclk);
            ev <= 5'h0;
            repeat (4) @(posedge pclk);
            chk(5'h1 << i);
            apb(1'h1, 12'h020, 32'h1F);
        end
        $display("source test done");
        apb(1'h1, 12'h01C, 32'h1F);
        apb(1'h1, 12'h020, 32'h05);
        chk(5'h1A);
        apb(1'h1, 12'h024, 32'h05);
        `CMP("irq", 1'h0, irq)
        apb(1'h1, 12'h024, 32'h02);
        `CMP("irq", 1'h1, irq)
        apb(1'h1, 12'h024, 32'h0);
        `CMP("irq", 1'h0, irq)
        $display("mask test done");
        apb(1'h0, 12'h040, 32'h0);
        `CMP("slverr", 1'h1, err)
        `CMP("rdata", 32'h0, rd)
        $display("unmapped test done");
        wrap_up;
    end
endmodule // pcif_irq_flags_test
